// *** rtl/srsm_map.svh ***
// Purpose: bit positions, reset values and widths of the service request status block
// Assumes: included by its bare name wherever the constants are needed
// Notes:   definitions only
`ifndef SRSM_MAP_SVH
`define SRSM_MAP_SVH

// status and mask bit positions
`define SRSM_BIT_DATA_READY   0
`define SRSM_BIT_DATA_READY_W 0
`define SRSM_BIT_DIG_INTR     1
`define SRSM_BIT_TIME_ALARM   2
`define SRSM_BIT_TIME_INTERV  3
`define SRSM_BIT_MSG_NOT_EXEC 4
`define SRSM_BIT_POWERUP      5
`define SRSM_BIT_SUMMARY      6
`define SRSM_BIT_MANUAL       7

// mask bits an enable command may touch: 0..4 and 7
`define SRSM_MASK_CMD_BITS    8'h9F
`define SRSM_STATUS_RESET     8'h00
`define SRSM_MASK_RESET       8'h00
`define SRSM_POLL_RESET       8'h00

// widths of the timing and event inputs
`define SRSM_TOD_W            17
`define SRSM_INTERVAL_W       32
`define SRSM_NOT_EXEC_CAUSES  6
`define SRSM_DATA_CMDS        5

`endif

// *** rtl/srsm_pkg.sv ***
// Purpose: types shared by the service request status block
// Assumes: constants come from srsm_map.svh
// Notes:   nothing here is imported; users write srsm_pkg::name
`include "srsm_map.svh"

package srsm_pkg;

    // command group from the bus command decoder
    typedef struct packed {
        logic       mask_wr;
        logic [7:0] mask_arg;
        logic       poll;
        logic       data_read;
        logic       report;
    } srsm_cmd_t;

    // same-clock event pulses from the measurement side
    typedef struct packed {
        logic                                  dvm_single_done;
        logic                                  stored_count_done;
        logic [`SRSM_DATA_CMDS-1:0]            data_cmd_done;
        logic [`SRSM_NOT_EXEC_CAUSES-1:0]      not_exec;
    } srsm_evt_t;

    typedef enum logic [3:0] {
        SRSM_PON_WAIT  = 4'b0001,
        SRSM_PON_SYNC  = 4'b0010,
        SRSM_PON_ARM   = 4'b0100,
        SRSM_PON_RUN   = 4'b1000
    } srsm_pon_t;

endpackage : srsm_pkg

// *** rtl/srsm_sync.sv ***
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to clock_in
// Notes:   only the second stage leaves this module
`timescale 1ns/10ps

module srsm_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_b_in,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : srsm_sync

// *** rtl/srsm_dec.sv ***
// Purpose: registered binary to three decimal digits for the text status report
// Assumes: value is stable in the cycle the start pulse is high
// Notes:   one cycle of latency; digits hold until the next start
`timescale 1ns/10ps

module srsm_dec (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    // request
    input  wire logic       start_in,
    input  wire logic [7:0] value_in,
    // answer
    output logic      [3:0] hundreds_out,
    output logic      [3:0] tens_out,
    output logic      [3:0] ones_out,
    output logic            done_out
);

    // shift-and-add-three, fully combinational over eight bits
    function automatic logic [11:0] to_bcd(input logic [7:0] bin);
        logic [19:0] sr;
        sr = {12'h000, bin};
        for (int i = 0; i < 8; i++) begin
            if (sr[11:8] > 4'h4) begin
                sr[11:8] = sr[11:8] + 4'h3;
            end
            if (sr[15:12] > 4'h4) begin
                sr[15:12] = sr[15:12] + 4'h3;
            end
            sr = {sr[18:0], 1'b0};
        end
        return sr[19:8];
    endfunction : to_bcd

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hundreds_out <= 4'h0;
            tens_out     <= 4'h0;
            ones_out     <= 4'h0;
        end else if (start_in) begin
            {hundreds_out, tens_out, ones_out} <= to_bcd(value_in);
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= start_in;
        end
    end

endmodule : srsm_dec

// *** rtl/srsm_top.sv ***
// Purpose: event status register, request mask and bus service request of a data acquisition unit
// Assumes: command pulses and event pulses come from logic on clock_in; key, strap and plug-in
//          interrupt are pins; rst_b_in is the power-on reset
// Notes:   one line per rule below
`timescale 1ns/10ps
`include "srsm_map.svh"

module srsm_top #(
    parameter int TOD_W      = `SRSM_TOD_W,
    parameter int INTERVAL_W = `SRSM_INTERVAL_W
) (
    // clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  rst_b_in,
    // front-panel and board pins
    input  wire logic                  manual_key_in,
    input  wire logic                  powerup_request_strap_in,
    input  wire logic                  plugin_intr_in,
    // commands from the bus decoder
    input  wire srsm_pkg::srsm_cmd_t   cmd_in,
    // measurement and sequencing events
    input  wire srsm_pkg::srsm_evt_t   evt_in,
    // clock and timer inputs
    input  wire logic [TOD_W-1:0]      time_of_day_in,
    input  wire logic                  alarm_load_in,
    input  wire logic [TOD_W-1:0]      alarm_time_in,
    input  wire logic                  interval_start_in,
    input  wire logic [INTERVAL_W-1:0] interval_len_in,
    // bus side
    output logic                       srq_out,
    output logic [7:0]                 poll_byte_out,
    output logic                       poll_valid_out,
    // registers seen by the rest of the unit
    output logic [7:0]                 event_status_out,
    output logic [7:0]                 request_enable_mask_out,
    // front panel
    output logic                       request_lamp_out,
    // text report
    output logic [3:0]                 report_hundreds_out,
    output logic [3:0]                 report_tens_out,
    output logic [3:0]                 report_ones_out,
    output logic                       report_valid_out
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection

    logic [2:0]       pins_sync;
    logic             key_sync;
    logic             strap_sync;
    logic             intr_sync;
    logic             key_prev_q;
    logic             intr_prev_q;

    srsm_sync #(
        .WIDTH(3)
    ) u_sync (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .async_in ({manual_key_in, powerup_request_strap_in, plugin_intr_in}),
        .sync_out (pins_sync)
    );

    assign key_sync   = pins_sync[2];
    assign strap_sync = pins_sync[1];
    assign intr_sync  = pins_sync[0];

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            key_prev_q  <= 1'b0;
            intr_prev_q <= 1'b0;
        end else begin
            key_prev_q  <= key_sync;
            intr_prev_q <= intr_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // power-on sequencing: the strap is caught after reset release, never under reset

    srsm_pkg::srsm_pon_t pon_q;
    logic                pon_fire;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pon_q <= srsm_pkg::SRSM_PON_WAIT;
        end else begin
            unique case (pon_q)
                // two edges pass before the synchroniser carries a real strap level
                srsm_pkg::SRSM_PON_WAIT: begin
                    pon_q <= srsm_pkg::SRSM_PON_SYNC;
                end
                srsm_pkg::SRSM_PON_SYNC: begin
                    pon_q <= srsm_pkg::SRSM_PON_ARM;
                end
                srsm_pkg::SRSM_PON_ARM: begin
                    pon_q <= srsm_pkg::SRSM_PON_RUN;
                end
                srsm_pkg::SRSM_PON_RUN: begin
                    pon_q <= srsm_pkg::SRSM_PON_RUN;
                end
                default: begin
                    pon_q <= srsm_pkg::SRSM_PON_WAIT;
                end
            endcase
        end
    end

    assign pon_fire = (pon_q == srsm_pkg::SRSM_PON_ARM) && strap_sync;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // interval timer and time alarm

    logic [INTERVAL_W-1:0] interval_cnt_q;
    logic                  interval_run_q;
    logic                  interval_done;
    logic [TOD_W-1:0]      alarm_q;
    logic                  alarm_match_q;
    logic                  alarm_hit;

    // the reference instant is the start pulse; a new start restarts the count
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            interval_cnt_q <= '0;
            interval_run_q <= 1'b0;
        end else if (interval_start_in) begin
            interval_cnt_q <= interval_len_in;
            interval_run_q <= (interval_len_in != '0);
        end else if (interval_run_q) begin
            interval_cnt_q <= interval_cnt_q - INTERVAL_W'(1);
            interval_run_q <= (interval_cnt_q != INTERVAL_W'(1));
        end
    end

    assign interval_done = interval_run_q && (interval_cnt_q == INTERVAL_W'(1)) && !interval_start_in;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            alarm_q <= '0;
        end else if (alarm_load_in) begin
            alarm_q <= alarm_time_in;
        end
    end

    // only the moment of becoming equal counts, not every cycle of equality
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            alarm_match_q <= 1'b1;
        end else begin
            alarm_match_q <= (time_of_day_in == alarm_q);
        end
    end

    assign alarm_hit = (time_of_day_in == alarm_q) && !alarm_match_q;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // event collection

    logic [7:0] evt_set;

    always_comb begin
        evt_set = 8'h00;
        evt_set[`SRSM_BIT_DATA_READY_W] = evt_in.dvm_single_done
                                        | evt_in.stored_count_done
                                        | (|evt_in.data_cmd_done);
        evt_set[`SRSM_BIT_DIG_INTR]     = intr_sync && !intr_prev_q;
        evt_set[`SRSM_BIT_TIME_ALARM]   = alarm_hit;
        evt_set[`SRSM_BIT_TIME_INTERV]  = interval_done;
        evt_set[`SRSM_BIT_MSG_NOT_EXEC] = |evt_in.not_exec;
        evt_set[`SRSM_BIT_POWERUP]      = pon_fire;
        evt_set[`SRSM_BIT_MANUAL]       = key_sync && !key_prev_q;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // request enable mask

    logic [7:0] mask_q;
    logic [7:0] mask_d;

    always_comb begin
        mask_d = mask_q;
        if (cmd_in.mask_wr) begin
            // the argument byte is the octal number's value, so each weight lands on its bit
            mask_d = (cmd_in.mask_arg & `SRSM_MASK_CMD_BITS)
                   | (mask_q & ~`SRSM_MASK_CMD_BITS);
        end
        if (pon_fire) begin
            mask_d[`SRSM_BIT_POWERUP] = 1'b1;
        end
        mask_d[`SRSM_BIT_SUMMARY] = 1'b0;
    end

    // a poll never touches the mask
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mask_q <= `SRSM_MASK_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // event status register

    logic [7:0] status_q;
    logic [7:0] status_d;
    logic       new_match;

    // an event is counted against the mask in force in the same cycle
    // the strap sets mask bit 5 in the same cycle as status bit 5, so it counts as matched
    assign new_match = |(evt_set & mask_q) | pon_fire;

    always_comb begin
        status_d = status_q | (evt_set & ~8'(1 << `SRSM_BIT_SUMMARY));
        if (cmd_in.data_read && !evt_set[`SRSM_BIT_DATA_READY_W]) begin
            status_d[`SRSM_BIT_DATA_READY_W] = 1'b0;
        end
        // summary: raised by a masked event, dropped by a poll; a fresh match wins the poll
        if (new_match) begin
            status_d[`SRSM_BIT_SUMMARY] = 1'b1;
        end else if (cmd_in.poll) begin
            status_d[`SRSM_BIT_SUMMARY] = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            status_q <= `SRSM_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // bus request line and lamp

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            srq_out <= 1'b0;
        end else begin
            srq_out <= status_d[`SRSM_BIT_SUMMARY];
        end
    end

    // the lamp shows that a masked manual request has gone out, until the poll answers it
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            request_lamp_out <= 1'b0;
        end else if (evt_set[`SRSM_BIT_MANUAL] && mask_q[`SRSM_BIT_MANUAL]) begin
            request_lamp_out <= 1'b1;
        end else if (cmd_in.poll) begin
            request_lamp_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // serial poll answer: the byte is the status before the poll clears the summary

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            poll_byte_out  <= `SRSM_POLL_RESET;
            poll_valid_out <= 1'b0;
        end else begin
            poll_valid_out <= cmd_in.poll;
            if (cmd_in.poll) begin
                poll_byte_out <= status_q;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            event_status_out        <= `SRSM_STATUS_RESET;
            request_enable_mask_out <= `SRSM_MASK_RESET;
        end else begin
            event_status_out        <= status_d;
            request_enable_mask_out <= mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // decimal text report

    srsm_dec u_dec (
        .clock_in     (clock_in),
        .rst_b_in     (rst_b_in),
        .start_in     (cmd_in.report),
        .value_in     (status_q),
        .hundreds_out (report_hundreds_out),
        .tens_out     (report_tens_out),
        .ones_out     (report_ones_out),
        .done_out     (report_valid_out)
    );

endmodule : srsm_top

// *** sim/srsm_assertions.sv ***
// Purpose: concurrent checks on the ports of the service request status block
// Assumes: single clock domain, reset active low
// Notes:   attached to srsm_top by the bind at the foot of this file
`timescale 1ns/10ps
`include "srsm_map.svh"

module srsm_assertions (
    // clock and reset
    input wire logic                clock_in,
    input wire logic                rst_b_in,
    // requests and events
    input wire srsm_pkg::srsm_cmd_t cmd_in,
    input wire srsm_pkg::srsm_evt_t evt_in,
    // answers
    input wire logic                srq_out,
    input wire logic [7:0]          poll_byte_out,
    input wire logic                poll_valid_out,
    input wire logic [7:0]          event_status_out,
    input wire logic [7:0]          request_enable_mask_out,
    input wire logic                request_lamp_out,
    input wire logic [3:0]          report_hundreds_out,
    input wire logic [3:0]          report_tens_out,
    input wire logic [3:0]          report_ones_out,
    input wire logic                report_valid_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    logic data_evt;
    assign data_evt = evt_in.dvm_single_done | evt_in.stored_count_done | (|evt_in.data_cmd_done);

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_req_up;
        srq_out && event_status_out[6];
    endsequence
    sequence s_req_gone;
        !srq_out && !event_status_out[6] && !request_lamp_out;
    endsequence

    property p_poll_ans; cmd_in.poll |=> poll_valid_out && poll_byte_out == $past(event_status_out); endproperty
    a_poll_ans: assert property (p_poll_ans) else $error("poll answer wrong");
    property p_poll_clr; cmd_in.poll && evt_in == '0 |=> s_req_gone; endproperty
    a_poll_clr: assert property (p_poll_clr) else $error("poll left request up");
    property p_mask_wr; cmd_in.mask_wr |=> request_enable_mask_out ==
        (($past(cmd_in.mask_arg) & `SRSM_MASK_CMD_BITS) | ($past(request_enable_mask_out) & 8'h20)); endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write wrong");
    property p_mask_keep; !cmd_in.mask_wr |=> (request_enable_mask_out & 8'hDF) == ($past(request_enable_mask_out) & 8'hDF); endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("mask changed unasked");
    property p_data_set; data_evt |=> event_status_out[0]; endproperty
    a_data_set: assert property (p_data_set) else $error("data ready not set");
    property p_not_exec; (|evt_in.not_exec) |=> event_status_out[4]; endproperty
    a_not_exec: assert property (p_not_exec) else $error("not executed not set");
    property p_masked_req; data_evt && request_enable_mask_out[0] |=> s_req_up; endproperty
    a_masked_req: assert property (p_masked_req) else $error("masked event raised no request");
    property p_sticky; 1'b1 |=> ($past(event_status_out) & ~event_status_out & 8'hBE) == 8'h00; endproperty
    a_sticky: assert property (p_sticky) else $error("status bit dropped");
    property p_data_clr; cmd_in.data_read && !data_evt |=> !event_status_out[0]; endproperty
    a_data_clr: assert property (p_data_clr) else $error("data read kept bit 0");
    property p_report; cmd_in.report |=> report_valid_out && report_hundreds_out == 4'($past(event_status_out) / 100)
        && report_tens_out == 4'(($past(event_status_out) / 10) % 10) && report_ones_out == 4'($past(event_status_out) % 10);
    endproperty
    a_report: assert property (p_report) else $error("report digits wrong");
    property p_lamp; $rose(request_lamp_out) |-> srq_out && event_status_out[7] && request_enable_mask_out[7]; endproperty
    a_lamp: assert property (p_lamp) else $error("lamp without masked manual request");
endmodule : srsm_assertions

bind srsm_top srsm_assertions i_srsm_assertions (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .cmd_in(cmd_in), .evt_in(evt_in), .srq_out(srq_out),
    .poll_byte_out(poll_byte_out), .poll_valid_out(poll_valid_out), .event_status_out(event_status_out),
    .request_enable_mask_out(request_enable_mask_out), .request_lamp_out(request_lamp_out),
    .report_hundreds_out(report_hundreds_out), .report_tens_out(report_tens_out),
    .report_ones_out(report_ones_out), .report_valid_out(report_valid_out));

// *** sim/srsm_ctrl_model.sv ***
// Purpose: bus controller that answers each service request with a serial poll
// Assumes: srq_in is the block's request level
// Notes:   wait_in sets how many cycles the controller lets pass first
`timescale 1ns/10ps

module srsm_ctrl_model (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    // behaviour
    input  wire logic       enable_in,
    input  wire logic [3:0] wait_in,
    // bus
    input  wire logic       srq_in,
    input  wire logic       poll_valid_in,
    output logic            poll_out
);
    logic [3:0] cnt_q;
    logic       busy_q;

    // one poll per request; none while an answer is pending, else a stale level polls twice
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q    <= 4'h0;
            busy_q   <= 1'b0;
            poll_out <= 1'b0;
        end else begin
            poll_out <= 1'b0;
            if (busy_q) begin
                busy_q <= !poll_valid_in;
            end else if (enable_in && srq_in) begin
                if (cnt_q == wait_in) begin
                    poll_out <= 1'b1;
                    busy_q   <= 1'b1;
                    cnt_q    <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule : srsm_ctrl_model

// *** sim/tb_srsm_top.sv ***
// Purpose: self-checking bench for srsm_top
// Assumes: pins stay quiet during random traffic
// Notes:   a cycle model predicts status, mask, request and answers
`timescale 1ns/10ps

`define CHK(g, w) begin checks++; if ((g) !== (w)) begin miscompares++; $display("[ERR] %0t got %0h want %0h", $time, g, w); end end

module tb_srsm_top;
    logic                clock_in = 1'b0;
    logic                rst_b_in = 1'b0;
    logic                key = 1'b0, strap = 1'b1, plug = 1'b0, alm_ld = 1'b0, iv_go = 1'b0, en = 1'b0;
    srsm_pkg::srsm_cmd_t cmd = '0, dcmd, c;
    srsm_pkg::srsm_evt_t evt = '0, e;
    logic [16:0]         tod = '0, alm = '0;
    logic [31:0]         iv_len = '0;
    logic [3:0]          pw = 4'h0, o_h, o_t, o_o;
    logic [7:0]          st, m, inj = 8'h00, pb, d, ev, o_pb, o_st, o_m;
    logic                m_poll, o_srq, o_pv, o_lamp, o_rv, lamp, pv, rv, chk = 1'b0;
    logic [7:0]          args [6] = '{8'hFF, 8'h40, 8'h20, 8'h80, 8'h11, 8'h01};
    int                  miscompares = 0, checks = 0, cyc = 0;

    always #4 clock_in = ~clock_in;
    always @(posedge clock_in) tod <= tod + 17'h1;
    always_comb begin
        dcmd      = cmd;
        dcmd.poll = cmd.poll | m_poll;
    end

    srsm_top i_srsm_top (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .manual_key_in(key), .powerup_request_strap_in(strap),
        .plugin_intr_in(plug), .cmd_in(dcmd), .evt_in(evt), .time_of_day_in(tod), .alarm_load_in(alm_ld),
        .alarm_time_in(alm), .interval_start_in(iv_go), .interval_len_in(iv_len), .srq_out(o_srq),
        .poll_byte_out(o_pb), .poll_valid_out(o_pv), .event_status_out(o_st),
        .request_enable_mask_out(o_m), .request_lamp_out(o_lamp), .report_hundreds_out(o_h),
        .report_tens_out(o_t), .report_ones_out(o_o), .report_valid_out(o_rv));

    srsm_ctrl_model i_srsm_ctrl_model (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .enable_in(en), .wait_in(pw),
        .srq_in(o_srq), .poll_valid_in(o_pv), .poll_out(m_poll));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] bcd(input logic [7:0] v);
        return {4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
    endfunction : bcd

    // reference model; inj carries pin and timer events the bench knows have landed
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {st, m, lamp, pv, rv} = '0;
        end else begin
            ev    = inj;
            ev[0] = ev[0] | evt.dvm_single_done | evt.stored_count_done | (|evt.data_cmd_done);
            ev[4] = ev[4] | (|evt.not_exec);
            {pv, pb, rv, d} = {dcmd.poll, st, dcmd.report, st};
            if (dcmd.poll) {st[6], lamp} = 2'b00;
            if (dcmd.data_read) st[0] = 1'b0;
            if (|(ev & m)) st[6] = 1'b1;
            if (ev[7] & m[7]) lamp = 1'b1;
            st = st | (ev & 8'hBF);
            if (dcmd.mask_wr) m = (dcmd.mask_arg & 8'h9F) | (m & 8'h20);
        end
    end

    always @(negedge clock_in) if (chk && rst_b_in) begin
        `CHK(o_st, st)
        `CHK(o_m, m)
        `CHK(o_srq, st[6])
        `CHK(o_lamp, lamp)
        `CHK(o_pv, pv)
        if (pv) `CHK(o_pb, pb)
        `CHK(o_rv, rv)
        if (rv) `CHK({o_h, o_t, o_o}, bcd(d))
    end

    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            $display("[ERR] %0t run did not finish", $time);
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(input srsm_pkg::srsm_cmd_t sc, input srsm_pkg::srsm_evt_t se);
        @(posedge clock_in);
        cmd <= sc;
        evt <= se;
    endtask : step

    // pins pass a synchroniser, so the model is told only once the block has surely seen them
    task automatic inject(input logic [7:0] b);
        repeat (8) @(posedge clock_in);
        @(negedge clock_in);
        inj = b;
        @(negedge clock_in);
        inj = 8'h00;
        chk = 1'b1;
    endtask : inject

    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    initial begin
        void'($urandom(44923));
        repeat (6) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        @(negedge clock_in);
        {st, m, chk} = {8'h60, 8'h20, 1'b1};
        step('0, '0);
        en <= 1'b1;
        repeat (20) @(posedge clock_in);
        $display("power-on request done");
        foreach (args[i]) begin
            c          = '0;
            c.mask_wr  = 1'b1;
            c.mask_arg = args[i];
            step(c, '0);
        end
        step('0, '0);
        @(negedge clock_in) `CHK(o_m, 8'h21)
        $display("mask writes done");
        for (int i = 0; i < 600; i++) begin
            c          = 12'($urandom & $urandom & $urandom);
            e          = 13'($urandom & $urandom & $urandom);
            c.mask_arg = 8'($urandom);
            if (c.mask_wr) e = '0;
            step(c, e);
            pw <= 4'($urandom);
        end
        step('0, '0);
        repeat (40) @(posedge clock_in);
        $display("random traffic done");
        c          = '0;
        c.mask_wr  = 1'b1;
        c.mask_arg = 8'h80;
        step(c, '0);
        step('0, '0);
        en <= 1'b0;
        @(negedge clock_in) chk = 1'b0;
        @(posedge clock_in) key <= 1'b1;
        inject(8'h80);
        @(negedge clock_in) chk = 1'b0;
        @(posedge clock_in) plug <= 1'b1;
        inject(8'h02);
        en <= 1'b1;
        repeat (20) @(posedge clock_in);
        {key, plug, en} <= 3'b000;
        $display("pin events done");
        @(negedge clock_in) chk = 1'b0;
        @(posedge clock_in);
        {alm_ld, alm, iv_go, iv_len} <= {1'b1, tod + 17'd12, 1'b1, 32'd10};
        @(posedge clock_in);
        {alm_ld, iv_go} <= 2'b00;
        repeat (6) @(posedge clock_in);
        @(negedge clock_in) `CHK(o_st[3:2], 2'b00)
        inject(8'h0C);
        $display("timer events done");
        @(negedge clock_in) chk = 1'b0;
        @(posedge clock_in) {strap, rst_b_in} <= 2'b00;
        repeat (3) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        @(negedge clock_in) `CHK({o_st, o_m, o_srq}, 17'h0)
        chk = 1'b1;
        repeat (10) @(posedge clock_in);
        $display("second reset done");
        final_report();
    end
endmodule : tb_srsm_top
